// ===== src/hcp_defines.svh
// Offsets, field positions, reset values and counts of the host-card port.
`ifndef HCP_DEFINES_SVH
`define HCP_DEFINES_SVH

// Host I/O block: sixteen byte addresses, offsets within the block.
`define HCP_H_CMD       4'h0
`define HCP_H_STATUS    4'h2
`define HCP_H_DATA      4'h4
`define HCP_H_CTRL      4'h6
`define HCP_H_AUX       4'h8

// Card-side APB byte addresses.
`define HCP_A_CMD       12'h000
`define HCP_A_STATUS    12'h004
`define HCP_A_DATA      12'h008
`define HCP_A_CTRL      12'h00c

// Host control fields.
`define HCP_HC_FLAG1    0
`define HCP_HC_FLAG2    1
`define HCP_HC_CMDIE    2
`define HCP_HC_DONEIE   3
`define HCP_HC_GATE     4
`define HCP_HC_FLUSH    5
`define HCP_HC_UPLOAD   6
`define HCP_HC_RESET    7'h00

// Card control fields.
`define HCP_CC_FLAG1    0
`define HCP_CC_CMDIE    3
`define HCP_CC_FLUSH    4
`define HCP_CC_RESET    5'h00

// FIFO size, pause spacing and pause length.
`define HCP_FIFO_WORDS  4'd10
`define HCP_FIFO_LAST   4'd9
`define HCP_PAUSE_LAST  4'd8
`define HCP_PAUSE_CYC   4'd1

`endif

// ===== src/hcp_pkg.sv
// Types of the host-card port.
package hcp_pkg;

  // State of one mailbox direction.
  typedef struct packed {
    logic       full;
    logic [7:0] data;
  } hcp_mbox_type;

  // State of the ten-word FIFO store.
  typedef struct packed {
    logic [9:0][15:0] mem;
    logic [3:0]       wp;
    logic [3:0]       rp;
    logic [3:0]       cnt;
  } hcp_fifo_type;

  // State of the port top level.
  typedef struct packed {
    logic [6:0]  hctl;
    logic        pause_dis;
    logic [4:0]  cctl;
    logic        flush_prev;
    logic        byte_pend;
    logic [7:0]  byte_lo;
    logic        byte_phase;
    logic        done;
    logic [3:0]  xfer_cnt;
    logic [3:0]  pause_cnt;
    logic        drq;
    logic        drq_oe;
    logic        irq;
    logic        irq_oe;
    logic [15:0] hrdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cdrq;
    logic        cirq;
  } hcp_top_type;

endpackage

// ===== src/hcp_fifo_if.sv
// Connection between the port logic and its FIFO store.
`timescale 1ns/100ps
interface hcp_fifo_if;
  logic        push;
  logic        pop;
  logic        flush;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [3:0]  cnt;
  logic        full;
  logic        empty;
  modport user  (output push, pop, flush, wdata, input rdata, cnt, full, empty);
  modport store (input push, pop, flush, wdata, output rdata, cnt, full, empty);
endinterface

// ===== src/hcp_mailbox.sv
// One direction of the byte mailbox.
`timescale 1ns/100ps
`include "hcp_defines.svh"
module hcp_mailbox (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       load_in,
  input  wire logic [7:0] data_in,
  input  wire logic       read_in,
  output logic            full_out,
  output logic [7:0]      data_out
);
  hcp_pkg::hcp_mbox_type s_r;
  hcp_pkg::hcp_mbox_type s_nxt;

  // A load into a full mailbox is dropped unless the reader empties it now.
  always_comb begin
    s_nxt = s_r;
    if (load_in && (!s_r.full || read_in)) begin
      s_nxt.data = data_in;
    end
    s_nxt.full = load_in | (s_r.full & ~read_in);
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign full_out = s_r.full;
  assign data_out = s_r.data;
endmodule

// ===== src/hcp_fifo.sv
// Ten-word FIFO store with flush of the ready state.
`timescale 1ns/100ps
`include "hcp_defines.svh"
module hcp_fifo (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  hcp_fifo_if.store   f
);
  hcp_pkg::hcp_fifo_type s_r;
  hcp_pkg::hcp_fifo_type s_nxt;
  logic                  do_push;
  logic                  do_pop;

  // Flush moves the read pointer onto the write pointer and keeps the words.
  always_comb begin
    s_nxt   = s_r;
    do_push = f.push && (s_r.cnt != `HCP_FIFO_WORDS);
    do_pop  = f.pop && (s_r.cnt != 4'd0);
    if (f.flush) begin
      s_nxt.rp  = s_r.wp;
      s_nxt.cnt = 4'd0;
    end else begin
      if (do_push) begin
        s_nxt.mem[s_r.wp] = f.wdata;
        s_nxt.wp = (s_r.wp == `HCP_FIFO_LAST) ? 4'd0 : 4'(s_r.wp + 4'd1);
      end
      if (do_pop) begin
        s_nxt.rp = (s_r.rp == `HCP_FIFO_LAST) ? 4'd0 : 4'(s_r.rp + 4'd1);
      end
      s_nxt.cnt = 4'(s_r.cnt + {3'd0, do_push} - {3'd0, do_pop});
    end
  end

  // State register.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign f.rdata = s_r.mem[s_r.rp];
  assign f.cnt   = s_r.cnt;
  assign f.full  = (s_r.cnt == `HCP_FIFO_WORDS);
  assign f.empty = (s_r.cnt == 4'd0);
endmodule

// ===== src/hcp_port.sv
// Host-card port: byte mailbox, data FIFO, DMA requests and status flags.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "hcp_defines.svh"

module hcp_port (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [9:0]  host_addr_in,
  input  wire logic [5:0]  host_base_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic [15:0] host_wdata_in,
  input  wire logic        slot16_in,
  input  wire logic        host_dack_in,
  input  wire logic        host_tc_in,
  output logic      [15:0] host_rdata_out,
  output logic             host_drq_out,
  output logic             host_drq_oe_out,
  output logic             host_irq_out,
  output logic             host_irq_oe_out,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             card_drq_out,
  output logic             card_cmd_irq_out
);
  hcp_pkg::hcp_top_type s_r;
  hcp_pkg::hcp_top_type s_nxt;
  hcp_fifo_if           fif ();

  logic       h2c_full;
  logic [7:0] h2c_data;
  logic       c2h_full;
  logic [7:0] c2h_data;
  logic       hsel;
  logic       hw;
  logic       hr;
  logic       upload;
  logic       gate;
  logic       host_ready;
  logic       card_ready;
  logic       xfer;
  logic       hdata_wr;
  logic       hdata_rd;
  logic       setup;
  logic       acc;
  logic       flush_fall;
  logic       host_push;
  logic       host_pop;
  logic       card_push;
  logic       card_pop;
  logic [7:0] host_status;
  logic [7:0] card_status;

  // Host address decode within the jumpered sixteen-byte block.
  assign hsel = (host_addr_in[9:4] == host_base_in);
  assign hw   = host_wr_in & hsel;
  assign hr   = host_rd_in & hsel;

  // Direction and gate come straight from the host control register.
  assign upload = s_r.hctl[`HCP_HC_UPLOAD];
  assign gate   = s_r.hctl[`HCP_HC_GATE];

  // Ready flags swap meaning with the transfer direction.
  assign host_ready = upload ? ~fif.empty : ~fif.full;
  assign card_ready = upload ? ~fif.full : ~fif.empty;

  // A DMA acknowledge counts only while the gate is open.
  assign xfer     = host_dack_in & gate;
  assign hdata_wr = (hw && host_addr_in[3:0] == `HCP_H_DATA) || (xfer && !upload);
  assign hdata_rd = (hr && host_addr_in[3:0] == `HCP_H_DATA) || (xfer && upload);

  // APB phases; the slave answers in the first access cycle.
  assign setup = psel_in & ~penable_in;
  assign acc   = psel_in & penable_in & s_r.pready;

  // Falling edge of the OR of both sides' flush bits.
  assign flush_fall = s_r.flush_prev &
                      ~(s_r.hctl[`HCP_HC_FLUSH] | s_r.cctl[`HCP_CC_FLUSH]);

  // FIFO movements; a full push or empty pop is turned away.
  assign host_push = hdata_wr & ~upload & ~fif.full;
  assign host_pop  = hdata_rd & upload & ~fif.empty;
  assign card_push = acc & pwrite_in & (paddr_in == `HCP_A_DATA) & upload & ~fif.full;
  assign card_pop  = acc & ~pwrite_in & (paddr_in == `HCP_A_DATA) & ~upload & ~fif.empty;

  // Status views; both carry mailbox state and the direction.
  assign host_status = {s_r.cctl[2:0], s_r.done, upload, host_ready, ~h2c_full,
                        c2h_full};
  assign card_status = {2'b00, s_r.hctl[1:0], upload, card_ready, ~c2h_full,
                        h2c_full};

  // Host to card mailbox path.
  hcp_mailbox u_h2c (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (hw && host_addr_in[3:0] == `HCP_H_CMD),
    .data_in  (host_wdata_in[7:0]),
    .read_in  (acc && !pwrite_in && paddr_in == `HCP_A_CMD),
    .full_out (h2c_full),
    .data_out (h2c_data)
  );

  // Card to host mailbox path.
  hcp_mailbox u_c2h (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (acc && pwrite_in && paddr_in == `HCP_A_CMD),
    .data_in  (pwdata_in[7:0]),
    .read_in  (hr && host_addr_in[3:0] == `HCP_H_CMD),
    .full_out (c2h_full),
    .data_out (c2h_data)
  );

  // Shared word store; only one side pushes in each direction.
  hcp_fifo u_fifo (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .f      (fif)
  );

  // FIFO drive. In byte mode a word is pushed only when its pair is complete.
  always_comb begin
    fif.flush = flush_fall;
    fif.push  = card_push | (host_push & (slot16_in | s_r.byte_pend));
    fif.pop   = card_pop | (host_pop & (slot16_in | s_r.byte_phase));
    if (card_push) begin
      fif.wdata = pwdata_in[15:0];
    end else if (slot16_in) begin
      fif.wdata = host_wdata_in;
    end else begin
      fif.wdata = {host_wdata_in[7:0], s_r.byte_lo};
    end
  end

  // Next-state logic of the whole port.
  always_comb begin
    s_nxt = s_r;
    s_nxt.flush_prev = s_r.hctl[`HCP_HC_FLUSH] | s_r.cctl[`HCP_CC_FLUSH];

    // Host register writes.
    if (hw && host_addr_in[3:0] == `HCP_H_CTRL) begin
      s_nxt.hctl = host_wdata_in[6:0];
    end
    if (hw && host_addr_in[3:0] == `HCP_H_AUX) begin
      s_nxt.pause_dis = host_wdata_in[0];
    end

    // Byte packing of an eight-bit host download; first byte is the low half.
    if (host_push && !slot16_in) begin
      s_nxt.byte_lo   = host_wdata_in[7:0];
      s_nxt.byte_pend = ~s_r.byte_pend;
    end

    // Host reads are answered on the next cycle.
    if (hr || host_pop) begin
      s_nxt.hrdata = 16'h0000;
      unique case (host_addr_in[3:0])
        `HCP_H_CMD:    s_nxt.hrdata = {8'h00, c2h_data};
        `HCP_H_STATUS: s_nxt.hrdata = {8'h00, host_status};
        `HCP_H_CTRL:   s_nxt.hrdata = {9'h000, s_r.hctl};
        `HCP_H_AUX:    s_nxt.hrdata = {15'h0000, s_r.pause_dis};
        default:       s_nxt.hrdata = 16'h0000;
      endcase
    end
    if (host_pop) begin
      if (slot16_in) begin
        s_nxt.hrdata = fif.rdata;
      end else begin
        s_nxt.hrdata = {8'h00, s_r.byte_phase ? fif.rdata[15:8] : fif.rdata[7:0]};
        s_nxt.byte_phase = ~s_r.byte_phase;
      end
    end

    // A flush also drops any half word in flight.
    if (flush_fall) begin
      s_nxt.byte_pend  = 1'b0;
      s_nxt.byte_phase = 1'b0;
    end

    // DMA done is set by terminal count and held only while the gate is open.
    s_nxt.done = gate & (s_r.done | (xfer & host_tc_in));

    // Nine-transfer pause counter.
    if (s_r.pause_cnt != 4'd0) begin
      s_nxt.pause_cnt = 4'(s_r.pause_cnt - 4'd1);
    end
    if (!gate || s_r.pause_dis) begin
      s_nxt.xfer_cnt = 4'd0;
    end else if (xfer) begin
      if (s_r.xfer_cnt == `HCP_PAUSE_LAST) begin
        s_nxt.xfer_cnt  = 4'd0;
        s_nxt.pause_cnt = `HCP_PAUSE_CYC;
      end else begin
        s_nxt.xfer_cnt = 4'(s_r.xfer_cnt + 4'd1);
      end
    end

    // Host request: gated, stopped by done, stall or pause.
    s_nxt.drq    = gate & ~s_nxt.done & host_ready & (s_nxt.pause_cnt == 4'd0);
    s_nxt.drq_oe = gate;

    // Host interrupt line floats when both sources are disabled.
    s_nxt.irq = (s_nxt.done & s_r.hctl[`HCP_HC_DONEIE]) |
                (c2h_full & s_r.hctl[`HCP_HC_CMDIE]);
    s_nxt.irq_oe = s_r.hctl[`HCP_HC_DONEIE] | s_r.hctl[`HCP_HC_CMDIE];

    // Card-side outputs are always driven.
    s_nxt.cdrq = card_ready;
    s_nxt.cirq = h2c_full & s_r.cctl[`HCP_CC_CMDIE];

    // APB slave: answer ready in the access cycle, error on unmapped addresses.
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && paddr_in != `HCP_A_CMD && paddr_in != `HCP_A_STATUS &&
                    paddr_in != `HCP_A_DATA && paddr_in != `HCP_A_CTRL;
    if (setup && !pwrite_in) begin
      unique case (paddr_in)
        `HCP_A_CMD:    s_nxt.prdata = {24'h000000, h2c_data};
        `HCP_A_STATUS: s_nxt.prdata = {24'h000000, card_status};
        `HCP_A_DATA:   s_nxt.prdata = {16'h0000, fif.rdata};
        `HCP_A_CTRL:   s_nxt.prdata = {27'h0000000, s_r.cctl};
        default:       s_nxt.prdata = 32'h00000000;
      endcase
    end
    if (acc && pwrite_in && paddr_in == `HCP_A_CTRL) begin
      s_nxt.cctl = pwdata_in[4:0];
    end
  end

  // State register; reset clears controls and empties both paths.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign host_rdata_out   = s_r.hrdata;
  assign host_drq_out     = s_r.drq;
  assign host_drq_oe_out  = s_r.drq_oe;
  assign host_irq_out     = s_r.irq;
  assign host_irq_oe_out  = s_r.irq_oe;
  assign prdata_out       = s_r.prdata;
  assign pready_out       = s_r.pready;
  assign pslverr_out      = s_r.pslverr;
  assign card_drq_out     = s_r.cdrq;
  assign card_cmd_irq_out = s_r.cirq;

  // Checks of the port behaviour.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A host command byte reaches the card interrupt two edges later.
  property p_cmd_irq;
    (hw && host_addr_in[3:0] == `HCP_H_CMD && !h2c_full && s_r.cctl[`HCP_CC_CMDIE] &&
     !(psel_in && penable_in) && !(hw && host_addr_in[3:0] == `HCP_H_CTRL))
      |=> h2c_full ##1 card_cmd_irq_out;
  endproperty
  a_cmd_irq: assert property (p_cmd_irq) else $error("card command irq missing");

  // A card read of the command byte empties the host-to-card path.
  property p_mbox_clear;
    (acc && !pwrite_in && paddr_in == `HCP_A_CMD &&
     !(hw && host_addr_in[3:0] == `HCP_H_CMD)) |=> !h2c_full;
  endproperty
  a_mbox_clear: assert property (p_mbox_clear) else $error("mailbox full not cleared");

  // A full mailbox keeps its byte against a further load.
  property p_mbox_keep;
    (h2c_full && !(acc && !pwrite_in && paddr_in == `HCP_A_CMD)) |=> $stable(h2c_data);
  endproperty
  a_mbox_keep: assert property (p_mbox_keep) else $error("full mailbox overwritten");

  // The store never holds more than ten words.
  property p_cap;
    fif.cnt <= `HCP_FIFO_WORDS;
  endproperty
  a_cap: assert property (p_cap) else $error("fifo over capacity");

  // The first byte of a pair is not visible to the card.
  property p_pack;
    (host_push && !slot16_in && !s_r.byte_pend && !card_pop && !flush_fall)
      |=> (fif.cnt == $past(fif.cnt));
  endproperty
  a_pack: assert property (p_pack) else $error("lone byte reached fifo");

  // A flush leaves the store reporting empty.
  property p_flush;
    flush_fall |=> (fif.cnt == 4'd0);
  endproperty
  a_flush: assert property (p_flush) else $error("flush did not empty");

  // Empty download store withdraws the card request.
  property p_card_drq;
    (!upload && fif.empty && !host_push) |=> !card_drq_out;
  endproperty
  a_card_drq: assert property (p_card_drq) else $error("card request while empty");

  // Closed gate floats the host request.
  property p_float;
    !gate |=> (!host_drq_oe_out && !host_drq_out);
  endproperty
  a_float: assert property (p_float) else $error("host request driven without gate");

  // The ninth transfer drops the request for the pause.
  property p_pause;
    (xfer && !s_r.pause_dis && s_r.xfer_cnt == `HCP_PAUSE_LAST) |=> !host_drq_out;
  endproperty
  a_pause: assert property (p_pause) else $error("pause missing after nine");

  // Terminal count with done enabled raises the host interrupt.
  property p_done_irq;
    (xfer && host_tc_in && s_r.hctl[`HCP_HC_DONEIE] &&
     !(hw && host_addr_in[3:0] == `HCP_H_CTRL)) |=> (host_irq_out && !host_drq_out);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done irq missing");

  // Clearing the gate clears done.
  property p_done_clr;
    !gate |=> !s_r.done;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done survived gate clear");

  // Main scenarios reached.
  c_byte_upload: cover property (host_pop && !slot16_in && s_r.byte_phase);
  c_pause:       cover property (s_r.pause_cnt != 4'd0 && gate);
  c_flush:       cover property (flush_fall && !fif.empty);
  c_done:        cover property (s_r.done && host_irq_out);
endmodule

// ===== dv/hcp_host_model.sv
// Host I/O bus and demand-mode DMA controller facing the host side of the port.
`timescale 1ns/100ps
module hcp_host_model (
  input  wire logic        clk_in,
  input  wire logic        drq_in,
  input  wire logic        drq_oe_in,
  input  wire logic        run_in,
  input  wire logic [4:0]  tc_at_in,
  input  wire logic [15:0] rdata_in,
  output logic      [9:0]  addr_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [15:0] wdata_out,
  output logic             dack_out,
  output logic             tc_out,
  output logic      [7:0]  low9_out,
  output logic      [7:0]  lowx_out
);
  logic       drq_w;
  logic [4:0] n_dack;
  logic       take;

  // A released request line is pulled low on the host board.
  assign drq_w = drq_oe_in & drq_in;
  assign take  = drq_w && !dack_out && n_dack < tc_at_in;

  // Bus idles with no strobe at time zero.
  initial begin
    addr_out  = 10'h000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 16'h0000;
  end

  // One-cycle write strobe; address and data are scrambled once released.
  task automatic hwr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  // One-cycle read strobe; data is taken in the cycle after it.
  task automatic hrd(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rdata_in;
  endtask

  // Acknowledges on alternate cycles, terminal count on the last, and counts request drops.
  always @(posedge clk_in) begin
    if (!run_in) begin
      n_dack   <= 5'h00;
      dack_out <= 1'b0;
      tc_out   <= 1'b0;
      low9_out <= 8'h00;
      lowx_out <= 8'h00;
    end else begin
      dack_out <= take;
      tc_out   <= take && n_dack == tc_at_in - 5'h01;
      if (take) begin
        n_dack <= n_dack + 5'h01;
      end
      if (!drq_w && n_dack != 5'h00 && n_dack < tc_at_in) begin
        if (n_dack == 5'h09) begin
          low9_out <= low9_out + 8'h01;
        end else begin
          lowx_out <= lowx_out + 8'h01;
        end
      end
    end
  end
endmodule

// ===== dv/hcp_port_tb.sv
// Self-checking bench of the host-card port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", n, e, g); end end
module hcp_port_tb;
  localparam logic [5:0] BASE = 6'h2a;
  logic        clk_in  = 1'b0;
  logic        rst_in  = 1'b1;
  logic        slot16  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        run     = 1'b0;
  logic [4:0]  tc_at   = 5'h0c;
  logic [15:0] lf      = 16'hff78;
  logic [31:0] rd, prdata;
  logic [15:0] h, b, c, hb_wd, hb_rdata;
  logic [15:0] q [10];
  logic [9:0]  hb_addr;
  logic [7:0]  low9, lowx;
  logic        err, hb_wr, hb_rd, hb_dack, hb_tc, drq, drq_oe, hirq, pready, pslverr, cdrq, cirq;
  logic        hioe;
  int          n_fail  = 0;
  int          n_tests = 0;
  int          cyc     = 0;

  hcp_port uut (.clk_in(clk_in), .rst_in(rst_in), .host_addr_in(hb_addr), .host_base_in(BASE),
    .host_wr_in(hb_wr), .host_rd_in(hb_rd), .host_wdata_in(hb_wd), .slot16_in(slot16),
    .host_dack_in(hb_dack), .host_tc_in(hb_tc), .host_rdata_out(hb_rdata), .host_drq_out(drq),
    .host_drq_oe_out(drq_oe), .host_irq_out(hirq), .host_irq_oe_out(hioe), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .card_drq_out(cdrq),
    .card_cmd_irq_out(cirq));

  hcp_host_model host (.clk_in(clk_in), .drq_in(drq), .drq_oe_in(drq_oe), .run_in(run),
    .tc_at_in(tc_at), .rdata_in(hb_rdata), .addr_out(hb_addr), .wr_out(hb_wr), .rd_out(hb_rd),
    .wdata_out(hb_wd), .dack_out(hb_dack), .tc_out(hb_tc), .low9_out(low9),
    .lowx_out(lowx));

  // Clock at 200 MHz.
  always #2.5 clk_in = ~clk_in;

  // Cycle ceiling cuts a hang short.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end

  // Next value of the sixteen-bit shift register.
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  // Host byte address of an offset in the port block.
  function automatic logic [9:0] ha(input logic [3:0] o);
    return {BASE, o};
  endfunction

  // One APB transfer; the answer is taken at the edge that sees pready high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask

  // One host DMA burst of twelve bytes in either direction, then gate closed and store flushed.
  // In upload the card first fills six words, so the store runs dry only at the last byte.
  task automatic dma(input logic pd, input logic up);
    host.hwr(ha(4'h8), {15'h0000, pd});
    host.hwr(ha(4'h6), {9'h000, up, 6'h08});
    for (int i = 0; i < 6 && up; i++) begin
      c = rnd();
      apb(1'b1, 12'h008, {16'h0000, c});
    end
    host.hwr(ha(4'h6), {9'h000, up, 6'h18});
    run <= 1'b1;
    for (int k = 0; k < 300 && hirq !== 1'b1; k++) @(posedge clk_in);
    if (up) begin
      `CHK("dma byte", {8'h00, c[15:8]}, hb_rdata)
    end
    `CHK("done irq", 1'b1, hirq)
    `CHK("irq oe", 1'b1, hioe)
    `CHK("drq end", 1'b0, drq)
    `CHK("drq oe", 1'b1, drq_oe)
    `CHK("pause", {7'h00, ~pd}, low9)
    `CHK("drop", 8'h00, lowx)
    `CHK("card drq", 1'b1, cdrq)
    host.hrd(ha(4'h2), h);
    `CHK("done", 1'b1, h[4])
    run <= 1'b0;
    host.hwr(ha(4'h6), 16'h0000);
    host.hrd(ha(4'h2), h);
    `CHK("done clr", 1'b0, h[4])
    `CHK("irq clr", 1'b0, hirq)
    `CHK("drq float", 1'b0, drq_oe)
    `CHK("irq float", 1'b0, hioe)
    host.hwr(ha(4'h6), 16'h0020);
    host.hwr(ha(4'h6), 16'h0000);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("flushed", 1'b0, rd[2])
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset view, mailbox, word and byte store, upload, DMA.
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    host.hrd(ha(4'h2), h);
    `CHK("host rst", 8'h06, h[7:0])
    apb(1'b0, 12'h004, 32'h0);
    `CHK("card rst", 6'h02, rd[5:0])
    apb(1'b1, 12'h010, 32'h1);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, 12'h00c, 32'h0000_000f);
    host.hwr(ha(4'h6), 16'h0007);
    b = rnd();
    c = rnd();
    host.hwr(ha(4'h0), {8'h00, b[7:0]});
    host.hwr(ha(4'h0), {8'h00, c[7:0]});
    apb(1'b1, 12'h000, {24'h0, c[7:0]});
    apb(1'b0, 12'h004, 32'h0);
    `CHK("card stat", 6'h31, rd[5:0])
    `CHK("card irq", 1'b1, cirq)
    host.hrd(ha(4'h2), h);
    `CHK("host stat", 8'he5, h[7:0])
    `CHK("host irq", 1'b1, hirq)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("card cmd", b[7:0], rd[7:0])
    host.hrd(ha(4'h0), h);
    `CHK("host cmd", c[7:0], h[7:0])
    apb(1'b0, 12'h004, 32'h0);
    `CHK("card irq", 1'b0, cirq)
    host.hrd(ha(4'h2), h);
    `CHK("host irq", 1'b0, hirq)
    for (int i = 0; i < 10; i++) begin
      q[i] = rnd();
      host.hwr(ha(4'h4), q[i]);
    end
    host.hwr(ha(4'h4), 16'h5a5a);
    host.hrd(ha(4'h2), h);
    `CHK("host full", 1'b0, h[2])
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 12'h008, 32'h0);
      `CHK("card data", q[i], rd[15:0])
    end
    apb(1'b0, 12'h004, 32'h0);
    `CHK("card empty", 1'b0, rd[2])
    slot16 <= 1'b0;
    b = rnd();
    c = rnd();
    host.hwr(ha(4'h4), b);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("half word", 1'b0, rd[2])
    host.hwr(ha(4'h4), c);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("pair", {c[7:0], b[7:0]}, rd[15:0])
    host.hwr(ha(4'h4), b);
    apb(1'b0, 12'h004, 32'h0);
    `CHK("lone byte", 1'b0, rd[2])
    apb(1'b1, 12'h00c, 32'h10);
    apb(1'b1, 12'h00c, 32'h00);
    host.hwr(ha(4'h4), c);
    host.hwr(ha(4'h4), b);
    apb(1'b0, 12'h008, 32'h0);
    `CHK("after flush", {b[7:0], c[7:0]}, rd[15:0])
    host.hwr({BASE ^ 6'h01, 4'h6}, 16'h0040);
    host.hrd(ha(4'h2), h);
    `CHK("base", 1'b0, h[3])
    host.hwr(ha(4'h6), 16'h0040);
    b = rnd();
    apb(1'b1, 12'h008, {16'h0000, b});
    apb(1'b0, 12'h004, 32'h0);
    `CHK("card up", 1'b1, rd[3])
    host.hrd(ha(4'h4), h);
    `CHK("lo byte", b[7:0], h[7:0])
    host.hrd(ha(4'h2), h);
    `CHK("byte left", 2'b11, h[3:2])
    host.hrd(ha(4'h4), h);
    `CHK("hi byte", b[15:8], h[7:0])
    host.hrd(ha(4'h2), h);
    `CHK("drained", 1'b0, h[2])
    dma(1'b0, 1'b0);
    dma(1'b1, 1'b0);
    dma(1'b0, 1'b1);
    results();
  end
endmodule
